// ---- rtl/bcp_top.sv ----
// Purpose: Bayer demosaic, white balance, RGB to YUV and output coding
// Assumes: Raw samples arrive on clk, one per raw_valid, rows in order
// Notes:   Four-stage pipeline, no back-pressure on the output
//
// The Avalon-MM slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module bcp_top
    import bcp_pkg::*;
#(
    parameter int LINE_DEPTH = 2 ** BCP_COL_W
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        raw_valid,
    input  wire logic        raw_sof,
    input  wire logic        raw_sol,
    input  wire logic [7:0]  raw_data,
    output logic             pix_valid,
    output logic             pix_sof,
    output logic             pix_sol,
    output logic      [15:0] pix_data
);

    bcp_state_s           st_reg;
    bcp_state_s           st_next;
    logic [7:0]           line_mem [LINE_DEPTH];
    logic [BCP_COL_W-1:0] col_in;
    logic                 line_start;

    function automatic logic [7:0] wb_clamp(input logic [7:0] x);
        return (x < BCP_WB_MIN) ? BCP_WB_MIN : x;
    endfunction : wb_clamp

    // Gain x*k/64, held at full scale on overflow
    function automatic logic [7:0] gain(input logic [7:0] x, input logic [7:0] k);
        logic [15:0] p;
        p = x * k;
        p = p >> BCP_WB_SHIFT;
        return (p[15:8] != 8'h00) ? 8'hff : p[7:0];
    endfunction : gain

    // Signed dot product, rounded to nearest, offset, then clamped
    function automatic logic [7:0] conv(
        input logic        [7:0] r,
        input logic        [7:0] g,
        input logic        [7:0] b,
        input logic signed [9:0] kr,
        input logic signed [9:0] kg,
        input logic signed [9:0] kb,
        input logic        [7:0] ofs
    );
        logic signed [19:0] acc;
        acc = kr * $signed({1'b0, r});
        acc = acc + kg * $signed({1'b0, g});
        acc = acc + kb * $signed({1'b0, b});
        acc = (acc + BCP_ROUND) >>> BCP_CONV_SHIFT;
        acc = acc + $signed({12'h000, ofs});
        if (acc < 0) begin
            return 8'h00;
        end
        if (acc > 20'sh000ff) begin
            return 8'hff;
        end
        return acc[7:0];
    endfunction : conv

    assign line_start = raw_sof || raw_sol;
    assign col_in     = line_start ? '0 : st_reg.col + BCP_COL_W'(1);

    always_comb begin
        logic [7:0] w [2][2];
        logic [7:0] up;
        logic       rowx;
        logic       fstx;
        logic       rr;
        logic       cc;
        logic [8:0] gs;
        for (int i = 0; i < 2; i++) begin
            for (int j = 0; j < 2; j++) begin
                w[i][j] = 8'h00;
            end
        end
        up      = 8'h00;
        rowx    = 1'b0;
        fstx    = 1'b0;
        rr      = 1'b0;
        cc      = 1'b0;
        gs      = 9'h000;
        st_next = st_reg;

        // Bus slave: one wait cycle, then answer
        st_next.waitreq = 1'b1;
        if ((avs_read || avs_write) && st_reg.waitreq) begin
            st_next.waitreq = 1'b0;
            st_next.rdata   = 32'h0000_0000;
            unique case ({avs_address[3:2], 2'b00})
                BCP_OFS_CTRL: begin
                    st_next.rdata[BCP_MODE_LSB +: 2]  = st_reg.mode;
                    st_next.rdata[BCP_PHASE_LSB +: 2] = st_reg.phase;
                end
                BCP_OFS_WB: begin
                    st_next.rdata[BCP_BLUE_LSB +: 8]  = st_reg.blue;
                    st_next.rdata[BCP_RED_LSB +: 8]   = st_reg.red;
                    st_next.rdata[BCP_GREEN_LSB +: 8] = BCP_GREEN_WB;
                end
                BCP_OFS_STAT: begin
                    st_next.rdata[15:0]         = st_reg.frames;
                    st_next.rdata[BCP_BUSY_BIT] = st_reg.s1.v || st_reg.s2.v || st_reg.s3.v;
                end
                default: st_next.rdata = 32'h0000_0000;
            endcase
        end
        if (avs_write && !st_reg.waitreq) begin
            if (({avs_address[3:2], 2'b00} == BCP_OFS_CTRL) && avs_byteenable[0]) begin
                st_next.mode  = bcp_mode_e'(avs_writedata[BCP_MODE_LSB +: 2]);
                st_next.phase = avs_writedata[BCP_PHASE_LSB +: 2];
            end
            if ({avs_address[3:2], 2'b00} == BCP_OFS_WB) begin
                if (avs_byteenable[0]) begin
                    st_next.blue = wb_clamp(avs_writedata[BCP_BLUE_LSB +: 8]);
                end
                if (avs_byteenable[1]) begin
                    st_next.red = wb_clamp(avs_writedata[BCP_RED_LSB +: 8]);
                end
            end
        end

        // Stage 1: 2x2 window and demosaic
        st_next.s1.v   = raw_valid;
        st_next.s1.sof = raw_valid && raw_sof;
        st_next.s1.sol = raw_valid && line_start;
        if (raw_valid) begin
            rowx    = raw_sof ? 1'b0 : (raw_sol ? !st_reg.row_odd : st_reg.row_odd);
            fstx    = raw_sof ? 1'b1 : (raw_sol ? 1'b0 : st_reg.first_row);
            up      = line_mem[col_in];
            w[0][0] = raw_data;
            w[0][1] = line_start ? raw_data : st_reg.prev_d;
            w[1][0] = fstx ? w[0][0] : up;
            w[1][1] = fstx ? w[0][1] : (line_start ? up : st_reg.prev_up);
            // Red sits where the window offset cancels the pixel parity
            rr = rowx ^ st_reg.phase[0];
            cc = col_in[0] ^ st_reg.phase[1];
            gs = {1'b0, w[rr][!cc]} + {1'b0, w[!rr][cc]};
            st_next.s1.c0  = w[rr][cc];
            st_next.s1.c1  = gs[8:1];
            st_next.s1.c2  = w[!rr][!cc];
            st_next.s1.raw = raw_data;
            st_next.s1.odd = col_in[0];
            st_next.col       = col_in;
            st_next.row_odd   = rowx;
            st_next.first_row = fstx;
            st_next.prev_d    = raw_data;
            st_next.prev_up   = up;
        end

        // Stage 2: white balance, saturating
        st_next.s2    = st_reg.s1;
        st_next.s2.c0 = gain(st_reg.s1.c0, st_reg.red);
        st_next.s2.c1 = gain(st_reg.s1.c1, BCP_GREEN_WB);
        st_next.s2.c2 = gain(st_reg.s1.c2, st_reg.blue);

        // Stage 3: RGB to YUV, chroma offset
        st_next.s3    = st_reg.s2;
        st_next.s3.c0 = conv(st_reg.s2.c0, st_reg.s2.c1, st_reg.s2.c2,
                             BCP_YR, BCP_YG, BCP_YB, 8'h00);
        st_next.s3.c1 = conv(st_reg.s2.c0, st_reg.s2.c1, st_reg.s2.c2,
                             BCP_UR, BCP_UG, BCP_UB, BCP_CHROMA_OFS);
        st_next.s3.c2 = conv(st_reg.s2.c0, st_reg.s2.c1, st_reg.s2.c2,
                             BCP_VR, BCP_VG, BCP_VB, BCP_CHROMA_OFS);

        // Stage 4: output coding; in UYVY and YUYV even pixels carry U, odd ones V
        st_next.out_v   = st_reg.s3.v;
        st_next.out_sof = st_reg.s3.sof;
        st_next.out_sol = st_reg.s3.sol;
        unique case (st_reg.mode)
            BCP_MODE_UYVY: st_next.out_data = {st_reg.s3.odd ? st_reg.s3.c2 : st_reg.s3.c1,
                                               st_reg.s3.c0};
            BCP_MODE_YUYV: st_next.out_data = {st_reg.s3.c0,
                                               st_reg.s3.odd ? st_reg.s3.c2 : st_reg.s3.c1};
            BCP_MODE_MONO: st_next.out_data = {8'h00, st_reg.s3.c0};
            BCP_MODE_RAW:  st_next.out_data = {8'h00, st_reg.s3.raw};
        endcase
        if (st_reg.s3.v && st_reg.s3.sof) begin
            st_next.frames = st_reg.frames + 16'h0001;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg         <= '0;
            st_reg.waitreq <= 1'b1;
            st_reg.blue    <= BCP_BLUE_RST;
            st_reg.red     <= BCP_RED_RST;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    // Previous row store, read before write at the same column
    always_ff @(posedge clk) begin
        if (ce && raw_valid) begin
            line_mem[col_in] <= raw_data;
        end
    end

    assign avs_readdata    = st_reg.rdata;
    assign avs_waitrequest = st_reg.waitreq;
    assign pix_valid       = st_reg.out_v;
    assign pix_sof         = st_reg.out_sof;
    assign pix_sol         = st_reg.out_sol;
    assign pix_data        = st_reg.out_data;

    // Checks
    logic [15:0] chk_r;
    logic [15:0] chk_b;
    logic [8:0]  chk_g;
    logic        gray2;
    assign chk_r = st_reg.s1.c0 * st_reg.red;
    assign chk_b = st_reg.s1.c2 * st_reg.blue;
    assign chk_g = {1'b0, st_reg.s1.c1} + {2'b00, st_reg.s1.c1[7:1]};
    assign gray2 = (st_reg.s2.c0 == st_reg.s2.c1) && (st_reg.s2.c1 == st_reg.s2.c2);

    default clocking cb @(posedge clk iff ce);
    endclocking
    default disable iff (rst);

    AST_BLUE_RST: assert property ($past(rst) |-> st_reg.blue == BCP_BLUE_RST)
        else $error("blue setting wrong after reset");
    AST_RED_RST: assert property ($past(rst) |-> st_reg.red == BCP_RED_RST)
        else $error("red setting wrong after reset");
    AST_WB_RANGE: assert property (st_reg.blue >= BCP_WB_MIN && st_reg.red >= BCP_WB_MIN)
        else $error("balance setting below accepted range");
    AST_GREEN_GAIN: assert property (st_reg.s1.v |=>
        st_reg.s2.c1 == (($past(chk_g) > 9'h0ff) ? 8'hff : $past(chk_g[7:0])))
        else $error("green gain is not 1.5");
    AST_RED_GAIN: assert property (st_reg.s1.v |=>
        st_reg.s2.c0 == (($past(chk_r) > 16'h3fff) ? 8'hff : $past(chk_r[13:6])))
        else $error("red gain is not setting over 64");
    AST_BLUE_GAIN: assert property (st_reg.s1.v |=>
        st_reg.s2.c2 == (($past(chk_b) > 16'h3fff) ? 8'hff : $past(chk_b[13:6])))
        else $error("blue gain is not setting over 64");
    AST_GRAY_LUMA: assert property (st_reg.s2.v && gray2 |=> st_reg.s3.c0 == $past(st_reg.s2.c0))
        else $error("gray pixel luma differs from input");
    AST_GRAY_CHROMA: assert property (st_reg.s2.v && gray2 |=>
        st_reg.s3.c1 == BCP_CHROMA_OFS && st_reg.s3.c2 == BCP_CHROMA_OFS)
        else $error("gray pixel chroma not at offset");
    AST_BLUE_U: assert property (st_reg.s2.v && st_reg.s2.c0 == 8'h00 && st_reg.s2.c1 == 8'h00
        && st_reg.s2.c2 == 8'hff |=> st_reg.s3.c1 == 8'hff && st_reg.s3.c0 == 8'h1c)
        else $error("pure blue conversion wrong");
    AST_RED_V: assert property (st_reg.s2.v && st_reg.s2.c0 == 8'hff && st_reg.s2.c1 == 8'h00
        && st_reg.s2.c2 == 8'h00 |=> st_reg.s3.c2 == 8'hff && st_reg.s3.c1 == 8'h54)
        else $error("pure red conversion wrong");
    AST_MONO_LUMA: assert property (st_reg.s3.v && st_reg.mode == BCP_MODE_MONO |=>
        pix_valid && pix_data == {8'h00, $past(st_reg.s3.c0)})
        else $error("mono output is not luma");
    AST_UYVY: assert property (st_reg.s3.v && st_reg.mode == BCP_MODE_UYVY |=> pix_data ==
        {$past(st_reg.s3.odd) ? $past(st_reg.s3.c2) : $past(st_reg.s3.c1), $past(st_reg.s3.c0)})
        else $error("4:2:2 word wrong");
    AST_YUYV: assert property (st_reg.s3.v && st_reg.mode == BCP_MODE_YUYV |=> pix_data ==
        {$past(st_reg.s3.c0), $past(st_reg.s3.odd) ? $past(st_reg.s3.c2) : $past(st_reg.s3.c1)})
        else $error("4:2:2 word wrong in luma-first order");
    AST_RAW: assert property (st_reg.s3.v && st_reg.mode == BCP_MODE_RAW |=>
        pix_valid && pix_data == {8'h00, $past(st_reg.s3.raw)})
        else $error("raw output is not the sample");
    AST_LATENCY: assert property (raw_valid |-> ##4 pix_valid)
        else $error("pixel lost in pipeline");
    AST_BUS_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest)
        else $error("bus request not answered");

    COV_MONO: cover property (pix_valid && st_reg.mode == BCP_MODE_MONO);
    COV_YUV_ODD: cover property (st_reg.s3.v && st_reg.s3.odd && st_reg.mode == BCP_MODE_YUYV);
    COV_WB_WRITE: cover property (avs_write && !avs_waitrequest && avs_address[3:2] == 2'b01);
    COV_FRAME: cover property (pix_valid && pix_sof);
    COV_SAT_CHROMA: cover property (st_reg.s3.v && st_reg.s3.c1 == 8'hff);

endmodule : bcp_top
`default_nettype wire

// ---- rtl/bcp_pkg.sv ----
// Purpose: Shared constants and types of the Bayer colour pipeline
// Assumes: 8-bit raw samples, 32-bit register bus
// Notes:   Conversion coefficients are scaled by 256
package bcp_pkg;
    // Register byte offsets
    localparam logic [3:0] BCP_OFS_CTRL = 4'h0;
    localparam logic [3:0] BCP_OFS_WB   = 4'h4;
    localparam logic [3:0] BCP_OFS_STAT = 4'h8;

    // Field positions
    localparam int BCP_MODE_LSB  = 0;
    localparam int BCP_PHASE_LSB = 2;
    localparam int BCP_BLUE_LSB  = 0;
    localparam int BCP_RED_LSB   = 8;
    localparam int BCP_GREEN_LSB = 16;
    localparam int BCP_BUSY_BIT  = 16;

    // White balance settings and reset values
    localparam logic [7:0] BCP_GREEN_WB = 8'h60;
    localparam logic [7:0] BCP_BLUE_RST = 8'ha0;
    localparam logic [7:0] BCP_RED_RST  = 8'h73;
    localparam logic [7:0] BCP_WB_MIN   = 8'h10;
    localparam int         BCP_WB_SHIFT = 6;

    // Colour conversion, coefficients times 256
    localparam logic signed [9:0]  BCP_YR = 10'sh04d;
    localparam logic signed [9:0]  BCP_YG = 10'sh097;
    localparam logic signed [9:0]  BCP_YB = 10'sh01c;
    localparam logic signed [9:0]  BCP_UR = 10'sh3d4;
    localparam logic signed [9:0]  BCP_UG = 10'sh3ac;
    localparam logic signed [9:0]  BCP_UB = 10'sh080;
    localparam logic signed [9:0]  BCP_VR = 10'sh080;
    localparam logic signed [9:0]  BCP_VG = 10'sh397;
    localparam logic signed [9:0]  BCP_VB = 10'sh3e9;
    localparam logic signed [19:0] BCP_ROUND = 20'sh00080;
    localparam int                 BCP_CONV_SHIFT = 8;
    localparam logic [7:0]         BCP_CHROMA_OFS = 8'h80;

    localparam int BCP_COL_W = 10;

    typedef enum logic [1:0] {
        BCP_MODE_UYVY,
        BCP_MODE_YUYV,
        BCP_MODE_MONO,
        BCP_MODE_RAW
    } bcp_mode_e;

    // One pixel in flight: c0..c2 are R,G,B or Y,U,V
    typedef struct packed {
        logic       v;
        logic       sof;
        logic       sol;
        logic       odd;
        logic [7:0] c0;
        logic [7:0] c1;
        logic [7:0] c2;
        logic [7:0] raw;
    } bcp_pix_s;

    typedef struct packed {
        logic                 waitreq;
        logic [31:0]          rdata;
        bcp_mode_e            mode;
        logic [1:0]           phase;
        logic [7:0]           blue;
        logic [7:0]           red;
        logic [15:0]          frames;
        logic [BCP_COL_W-1:0] col;
        logic                 row_odd;
        logic                 first_row;
        logic [7:0]           prev_d;
        logic [7:0]           prev_up;
        bcp_pix_s             s1;
        bcp_pix_s             s2;
        bcp_pix_s             s3;
        logic                 out_v;
        logic                 out_sof;
        logic                 out_sol;
        logic [15:0]          out_data;
    } bcp_state_s;
endpackage : bcp_pkg

// ---- bench/bcp_ccd_src.sv ----
// Purpose: Raw Bayer sample source in place of the sensor readout
// Assumes: A sample counts only on an edge with ce high
// Notes:   Idle data is the last value inverted on each gap cycle, and once after the frame
`timescale 1ns/1ps
`default_nettype none
module bcp_ccd_src
    import bcp_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       ce,
    input  wire logic [7:0] sample,
    output logic            raw_valid,
    output logic            raw_sof,
    output logic            raw_sol,
    output logic      [7:0] raw_data
);
    initial begin
        raw_valid = 1'b0;
        raw_sof = 1'b0;
        raw_sol = 1'b0;
        raw_data = 8'h00;
    end

    // Called just after a rising edge; rows of w samples, optional gaps
    // With use_fill each 2x2 site takes its own byte of fill
    task automatic frame(input int w, input int h, input bit gaps,
                         input logic [31:0] fill, input bit use_fill);
        int r;
        int c;
        int g;
        for (r = 0; r < h; r++) begin
            for (c = 0; c < w; c++) begin
                for (g = 0; g < 3 && gaps && sample[1:0] == 2'h0; g++) begin
                    raw_valid <= 1'b0;
                    raw_data <= ~raw_data;
                    @(posedge clk);
                end
                raw_valid <= 1'b1;
                raw_sof <= (r == 0 && c == 0);
                raw_sol <= (c == 0);
                raw_data <= use_fill ? fill[{r[0], c[0], 3'h0} +: 8] : sample;
                @(posedge clk);
                for (g = 0; g < 64 && !ce; g++) @(posedge clk);
            end
        end
        raw_valid <= 1'b0;
        raw_sof <= 1'b0;
        raw_sol <= 1'b0;
        raw_data <= ~raw_data;
    endtask : frame
endmodule : bcp_ccd_src
`default_nettype wire

// ---- bench/test_bayer_color_pipeline.sv ----
// Purpose: Self-checking bench of the colour pipeline against a model
// Assumes: Settings change only while the pipeline is empty
// Notes:   Edge pixels are counted; their data is compared only in raw mode
`timescale 1ns/1ps
`default_nettype none
module test_bayer_color_pipeline
    import bcp_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'h0;
    logic        avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rnd = 32'haa3c;
    logic        raw_valid, raw_sof, raw_sol, pix_valid, pix_sof, pix_sol;
    logic [7:0]  raw_data;
    logic [15:0] pix_data;
    bcp_mode_e   cur_mode = BCP_MODE_UYVY;
    bit          ce_rand = 1'b0;
    int          n_errors = 0, n_checks = 0, ph = 0, gb = 160, gr = 115, row = 0, col = 0;
    int          lcur[1024], lup[1024], p[4] = '{-1, -1, -1, -1};

    bcp_top dut (.clk(clk), .rst(rst), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .raw_valid(raw_valid),
        .raw_sof(raw_sof), .raw_sol(raw_sol), .raw_data(raw_data), .pix_valid(pix_valid),
        .pix_sof(pix_sof), .pix_sol(pix_sol), .pix_data(pix_data));
    bcp_ccd_src src (.clk(clk), .ce(ce), .sample(rnd[7:0]), .raw_valid(raw_valid),
        .raw_sof(raw_sof), .raw_sol(raw_sol), .raw_data(raw_data));

    always #12.5 clk = ~clk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs

    always @(posedge clk) begin
        rnd <= xs(rnd);
        ce <= ce_rand ? rnd[2:0] != 3'h0 : 1'b1;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic results;
        if (n_errors == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results

    function automatic int sat(input int v);
        return v < 0 ? 0 : (v > 255 ? 255 : v);
    endfunction : sat

    // Expected word plus sof, sol and compare flags above bit 15
    function automatic int pixel(input int c, l, a, al, input bit sof, sol);
        int v[4];
        int rgb[3];
        int k, y, u, w, ch;
        v = '{c, l, a, al};
        rgb = '{0, 0, 0};
        for (k = 0; k < 4; k++) begin
            rgb[(((row - k / 2) ^ ph) & 1) + (((col - k % 2) ^ (ph >> 1)) & 1)] += v[k];
        end
        rgb[0] = sat(rgb[0] * gr >>> 6);
        rgb[1] = sat((rgb[1] >>> 1) * 96 >>> 6);
        rgb[2] = sat(rgb[2] * gb >>> 6);
        y = sat((77 * rgb[0] + 151 * rgb[1] + 28 * rgb[2] + 128) >>> 8);
        u = sat(((-44 * rgb[0] - 84 * rgb[1] + 128 * rgb[2] + 128) >>> 8) + 128);
        w = sat(((128 * rgb[0] - 105 * rgb[1] - 23 * rgb[2] + 128) >>> 8) + 128);
        ch = col[0] ? w : u;
        case (cur_mode)
            BCP_MODE_UYVY: w = ch << 8 | y;
            BCP_MODE_YUYV: w = y << 8 | ch;
            BCP_MODE_MONO: w = y;
            default:       w = c;
        endcase
        return w | sof << 16 | (sof | sol) << 17 | (row > 0 && col > 0 || cur_mode == BCP_MODE_RAW) << 18;
    endfunction : pixel

    // Output seen at the fourth enabled edge after the one taking the sample
    always @(posedge clk) begin : monitor
        int e, k;
        if (rst) p = '{default: -1};
        else if (ce) begin
            e = p[3];
            check(pix_valid, e >= 0);
            if (e >= 0) check({pix_sol, pix_sof}, e[17:16]);
            if (e >= 0 && e[18]) check(pix_data, e[15:0]);
            for (k = 3; k > 0; k--) p[k] = p[k - 1];
            p[0] = -1;
            if (raw_valid) begin
                if (raw_sof) row = 0;
                else if (raw_sol) row++;
                if (raw_sol && !raw_sof) lup = lcur;
                col = (raw_sof || raw_sol) ? 0 : col + 1;
                lcur[col] = raw_data;
                p[0] = pixel(raw_data, col == 0 ? raw_data : lcur[col - 1], lup[col],
                             col == 0 ? 0 : lup[col - 1], raw_sof, raw_sol);
            end
        end
    end

    task automatic bus(input bit wr, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] q);
        int t;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_read <= !wr;
        avs_write <= wr;
        for (t = 0; t < 100; t++) begin
            @(posedge clk);
            if (!avs_waitrequest) break;
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (t == 100) begin
            n_errors++;
            results();
        end
    endtask : bus

    // One 8x4 frame, then wait until the model's pipeline is empty
    task automatic frame_drain(input bit gaps, input logic [31:0] fill, input bit use_fill);
        int t;
        src.frame(8, 4, gaps, fill, use_fill);
        ce_rand = 1'b0;
        for (t = 0; t < 200 && p.sum() != -4; t++) @(posedge clk);
        if (t == 200) begin
            n_errors++;
            results();
        end
    endtask : frame_drain

    initial begin
        logic [31:0] q;
        int i, wb;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        bus(0, BCP_OFS_WB, 32'h0, 4'hf, q);
        check(q, 32'h006073a0);
        bus(0, BCP_OFS_CTRL, 32'h0, 4'hf, q);
        check(q, 32'h0);
        bus(1, BCP_OFS_WB, 32'hffffff05, 4'h1, q);
        bus(1, BCP_OFS_WB, 32'h00000c00, 4'h2, q);
        bus(1, 4'hc, 32'hffffffff, 4'hf, q);
        bus(0, 4'hc, 32'h0, 4'hf, q);
        check(q, 32'h0);
        bus(0, BCP_OFS_WB, 32'h0, 4'hf, q);
        check(q, 32'h00601010);
        for (i = 0; i < 12; i++) begin
            cur_mode = bcp_mode_e'(i % 4);
            ph = (i / 4 + i) % 4;
            gb = i == 0 ? 16 : (i == 1 ? 255 : 16 + rnd % 240);
            gr = i == 1 ? 16 : (i == 0 ? 255 : 16 + rnd / 7 % 240);
            wb = i == 2 ? 5 : gb;
            gb = i == 2 ? 16 : gb;
            bus(1, BCP_OFS_CTRL, ph << 2 | cur_mode, 4'h1, q);
            bus(1, BCP_OFS_WB, 32'h00ff0000 | gr << 8 | wb, 4'h7, q);
            bus(0, BCP_OFS_WB, 32'h0, 4'hf, q);
            check(q, 32'h00600000 | gr << 8 | gb);
            bus(0, BCP_OFS_CTRL, 32'h0, 4'hf, q);
            check(q[3:0], ph << 2 | cur_mode);
            ce_rand = i[0];
            frame_drain(i[1], 32'h0, 1'b0);
        end
        // Pure red, pure blue and black frames, phase 0, gains of 2
        cur_mode = BCP_MODE_UYVY;
        ph = 0;
        gb = 128;
        gr = 128;
        bus(1, BCP_OFS_CTRL, 32'h0, 4'h1, q);
        bus(1, BCP_OFS_WB, 32'h00008080, 4'h3, q);
        frame_drain(1'b0, 32'h000000ff, 1'b1);
        frame_drain(1'b0, 32'hff000000, 1'b1);
        frame_drain(1'b0, 32'h00000000, 1'b1);
        bus(0, BCP_OFS_STAT, 32'h0, 4'hf, q);
        check(q, 32'h0000000f);
        results();
    end
endmodule : test_bayer_color_pipeline
`default_nettype wire
